// >>> dv/rxf_host.sv
/* Host model: APB master and drain routines. Needs ref_clk and one APB slave. */
`timescale 1ns/1ps
module rxf_host (
   input  logic        ref_clk,
   input  logic        pready,
   input  logic [31:0] prdata,
   output logic        psel,
   output logic        penable,
   output logic        pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   logic [7:0] got [8];
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task drain8();
      logic [31:0] r;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b0, 12'h014, '0, r);
         got[i] = r[7:0];
      end
   endtask
   task poll(output logic [31:0] s1, output logic [31:0] s2);
      xfer(1'b0, 12'h000, '0, s1);
      s2 = s1;
      if (s1[4] && !s1[5]) xfer(1'b0, 12'h000, '0, s2);
   endtask
endmodule

// >>> dv/rxf_props.sv
/* Port checker of rxf_flags. Sees only its ports. */
`timescale 1ns/1ps
module rxf_props (
   input logic        ref_clk,
   input logic        rst,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic        pready,
   input logic [31:0] prdata,
   input logic        pslverr,
   input logic        irq,
   input logic        rx_valid_packet,
   input logic        rx_bad_crc,
   input logic        rx_early_end,
   input logic        rx_type_error,
   input logic        packet_start_symbol,
   input logic        ack_sent
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire fe = rx_bad_crc | rx_early_end | rx_type_error;
   wire ev = fe | rx_valid_packet | ack_sent | packet_start_symbol;
   wire rd0 = psel & penable & ~pwrite & (paddr == 12'h000);
   wire rs0 = psel & ~penable & ~pwrite & (paddr == 12'h000);
   sequence quiet_rds;
      rs0 && !ev ##1 (!rs0 && !ev) [*2] ##1 rs0 && !ev;
   endsequence
   ready_high_a: assert property (pready) else $error("ready low");
   map_err_a: assert property (psel && penable && paddr >= 12'h018 |-> pslverr)
      else $error("no slave error");
   idle_err_a: assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
   reset_quiet_a: assert property (disable iff (1'b0) rst |=> prdata == 0 && !irq)
      else $error("reset state");
   fault_cause_a: assert property (fe ##1 (!rd0) [*2] ##1 rd0 |=> prdata[5])
      else $error("fault missing");
   read_clear_a: assert property (quiet_rds |=> prdata[5:4] == 2'h0)
      else $error("done not cleared");
   fill_order_a: assert property (rd0 |=> !prdata[0] || prdata[2:1] == 2'h3)
      else $error("fill flags");
   read_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved");
endmodule
bind rxf_flags rxf_props u_props (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pready,
   .prdata, .pslverr, .irq, .rx_valid_packet, .rx_bad_crc, .rx_early_end, .rx_type_error,
   .packet_start_symbol, .ack_sent);

// >>> dv/tb_rxf_flags.sv
/* Top bench of rxf_flags. Needs rxf_host and the bound rxf_props. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
   $display("unexpected %0t got %h exp %h", $time, a, b); end end
module tb_rxf_flags;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  pl = '0;
   logic [7:0]  rx_byte = '0;
   logic        zs = 1'b0;
   logic [31:0] seed = 32'hfffb;
   logic [31:0] r, s2;
   logic [7:0]  q [$];
   logic [7:0]  e;
   int          fail_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   wire         psel, penable, pwrite, pready, pslverr, irq;
   wire [11:0]  paddr;
   wire [31:0]  pwdata, prdata;
   rxf_host h (.ref_clk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
   rxf_flags dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .rx_byte_valid(pl[0]), .rx_byte, .packet_start_symbol(pl[1]),
      .packet_end_symbol(pl[2]), .rx_valid_packet(pl[3]), .rx_bad_crc(pl[4]),
      .rx_early_end(pl[5]), .rx_type_error(pl[6]), .rx_zero_seed(zs), .ack_sent(pl[7]), .irq);
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function logic [2:0] fill(int n);
      return {n > 0, n >= 8, n == 16};
   endfunction
   task pulse(int i);
      pl[i] <= 1'b1;
      @(posedge ref_clk);
      pl <= '0;
      @(posedge ref_clk);
   endtask
   task rd(logic [11:0] a);
      h.xfer(1'b0, a, '0, r);
   endtask
   task wr(logic [11:0] a, logic [31:0] d);
      h.xfer(1'b1, a, d, s2);
   endtask
   task test_done();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial forever #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         test_done();
      end
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      wr(12'h004, 32'h4);
      for (int n = 1; n <= 17; n++) begin
         r = xs();
         rx_byte <= r[7:0];
         zs <= r[8];
         if (n <= 16) q.push_back(r[7:0]);
         pulse(0);
         rd(12'h000);
         `CHK(r[2:0], fill(n > 16 ? 16 : n))
         `CHK(irq, 1'b1)
      end
      `CHK(r[3], 1'b1)
      wr(12'h004, 32'h0);
      `CHK(irq, 1'b0)
      repeat (2) begin
         h.drain8();
         for (int i = 0; i < 8; i++) begin
            e = q.pop_front();
            `CHK(h.got[i], e)
         end
         rd(12'h000);
         `CHK(r[2:0], fill(q.size()))
      end
      wr(12'h008, 32'h4);
      pulse(1);
      pulse(2);
      rd(12'h000);
      `CHK(r[3], 1'b0)
      rd(12'h014);
      rd(12'h000);
      `CHK(r[3], 1'b1)
      for (int k = 4; k <= 6; k++) begin
         pulse(k);
         h.poll(r, s2);
         `CHK(r[5], 1'b1)
      end
      pulse(0);
      pulse(1);
      pulse(2);
      rd(12'h000);
      `CHK(r[5], 1'b1)
      rd(12'h014);
      rd(12'h00c);
      `CHK(r[3:0], 4'hf)
      wr(12'h00c, 32'h5);
      rd(12'h00c);
      `CHK(r[3:0], 4'ha)
      wr(12'h008, 32'h5);
      pulse(1);
      pulse(3);
      rd(12'h000);
      `CHK(r[4], 1'b0)
      pulse(7);
      h.poll(r, s2);
      `CHK({r[4], s2[4]}, 2'h2)
      wr(12'h008, 32'h4);
      pulse(3);
      h.poll(r, s2);
      `CHK(r[4], 1'b1)
      `CHK(r[6], zs)
      rd(12'h018);
      `CHK(r, 32'h0)
      test_done();
   end
endmodule

// >>> rtl/rxf_fifo.v
/*
 Receive byte buffer in flip-flops with fill level output.
 Assumes one write and one read port in the ref_clk domain, sync reset.
*/
`timescale 1ns/1ps
module rxf_fifo #(
   parameter W  = 8,
   parameter D  = 16,
   parameter AW = 4
) (
   input  wire          ref_clk,
   input  wire          rst,
   input  wire          clr,
   input  wire          wr_en,
   input  wire [W-1:0]  wr_data,
   input  wire          rd_en,
   output wire [W-1:0]  rd_data,
   output reg  [AW:0]   level_q
);
   reg [W-1:0]  mem_q [0:D-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   wire         full  = (level_q == D[AW:0]);
   wire         empty = (level_q == {(AW+1){1'b0}});
   wire         do_wr = wr_en & ~full;
   wire         do_rd = rd_en & ~empty;

   assign rd_data = mem_q[rp_q];

   always @(posedge ref_clk) begin
      if (rst | clr) begin
         wp_q    <= {AW{1'b0}};
         rp_q    <= {AW{1'b0}};
         level_q <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            mem_q[wp_q] <= wr_data;
            wp_q        <= wp_q + 1'b1;
         end
         if (do_rd) begin
            rp_q <= rp_q + 1'b1;
         end
         if (do_wr & ~do_rd) begin
            level_q <= level_q + 1'b1;
         end else if (do_rd & ~do_wr) begin
            level_q <= level_q - 1'b1;
         end
      end
   end
endmodule

// >>> rtl/rxf_flags.v
/*
 Receive status flags with an APB register port and a masked interrupt.
 Assumes the radio front end gives one-cycle event pulses on ref_clk.
*/
`timescale 1ns/1ps
`include "rxf_map.vh"
// Contract
// - full flag tracks buffer completely full
// - half flag at eight or more bytes
// - error on empty read or overrun
// - done after ack in transaction mode
// - reading status clears done flag
// - ack mode error may skip done
module rxf_flags #(
   parameter DEPTH = `RXF_DEPTH,
   parameter HALF  = `RXF_HALF_LEVEL
) (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   input  wire        rx_byte_valid,
   input  wire [7:0]  rx_byte,
   input  wire        packet_start_symbol,
   input  wire        packet_end_symbol,
   input  wire        rx_valid_packet,
   input  wire        rx_bad_crc,
   input  wire        rx_early_end,
   input  wire        rx_type_error,
   input  wire        rx_zero_seed,
   input  wire        ack_sent,
   output wire        irq
);
   // =======================================================================
   // Bus decode.
   wire acc   = psel & penable;
   wire wr    = acc & pwrite;
   // Reads are captured in the setup cycle so that prdata stands at the access edge.
   wire rd    = psel & ~penable & ~pwrite;
   wire a_st  = (paddr == `RXF_STATUS_OFS);
   wire a_mk  = (paddr == `RXF_MASK_OFS);
   wire a_ct  = (paddr == `RXF_CTRL_OFS);
   wire a_ev  = (paddr == `RXF_EVENT_OFS);
   wire a_lv  = (paddr == `RXF_LEVEL_OFS);
   wire a_dt  = (paddr == `RXF_DATA_OFS);
   wire known = a_st | a_mk | a_ct | a_ev | a_lv | a_dt;
   assign pready  = 1'b1;
   assign pslverr = acc & ~known;

   reg  [2:0]  ctrl_q;
   reg  [6:0]  mask_q;
   reg         buferr_q;
   reg         done_q;
   reg         fault_q;
   reg         zseed_q;
   reg         wait_ack_q;
   reg         in_pkt_q;
   reg  [3:0]  ev_q;
   wire [4:0]  level;
   wire [7:0]  rd_byte;
   wire        trans = ctrl_q[`RXF_CT_TRANS];
   wire        go    = ctrl_q[`RXF_CT_GO];
   wire        dat_rd = rd & a_dt;
   wire        st_rd  = rd & a_st;

   // =======================================================================
   // Buffer.
   rxf_fifo #(.W(8), .D(DEPTH), .AW(4)) u_fifo (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clr     (1'b0),
      .wr_en   (rx_byte_valid),
      .wr_data (rx_byte),
      .rd_en   (dat_rd),
      .rd_data (rd_byte),
      .level_q (level)
   );

   wire full_f  = (level == DEPTH[4:0]);
   wire half_f  = (level >= HALF[4:0]);
   wire nempty_f = (level != 5'h00);

   wire [6:0] status = {zseed_q, fault_q, done_q, buferr_q, nempty_f, half_f, full_f};

   wire drop_ev = packet_start_symbol & nempty_f & ~in_pkt_q;

   // =======================================================================
   // Flag state.
   always @(posedge ref_clk) begin
      if (rst) begin
         ctrl_q     <= `RXF_CTRL_RST;
         mask_q     <= `RXF_MASK_RST;
         buferr_q   <= 1'b0;
         done_q     <= 1'b0;
         fault_q    <= 1'b0;
         zseed_q    <= 1'b0;
         wait_ack_q <= 1'b0;
         in_pkt_q   <= 1'b0;
         ev_q       <= 4'h0;
      end else begin
         if (wr & a_mk) begin
            mask_q <= pwdata[6:0];
         end
         if (wr & a_ct) begin
            ctrl_q <= pwdata[2:0];
         end
         if (packet_start_symbol) begin
            in_pkt_q <= 1'b1;
         end else if (packet_end_symbol | rx_valid_packet) begin
            in_pkt_q <= 1'b0;
         end
         if ((dat_rd & ~nempty_f) | (rx_byte_valid & full_f)) begin
            buferr_q <= 1'b1;
         end else if (go & packet_start_symbol) begin
            buferr_q <= 1'b0;
         end
         if (rx_valid_packet & trans) begin
            wait_ack_q <= 1'b1;
         end else if (ack_sent | packet_start_symbol) begin
            wait_ack_q <= 1'b0;
         end
         if ((rx_valid_packet & ~trans) | (wait_ack_q & ack_sent)) begin
            done_q <= 1'b1;
         end else if (st_rd) begin
            done_q <= 1'b0;
         end
         if (rx_valid_packet) begin
            zseed_q <= rx_zero_seed;
         end
         if (rx_bad_crc | rx_early_end | rx_type_error | drop_ev) begin
            fault_q <= 1'b1;
         end else if (st_rd) begin
            fault_q <= 1'b0;
         end
         if (wr & a_ev) begin
            ev_q <= (ev_q & ~pwdata[3:0]) |
                    {drop_ev, rx_type_error, rx_early_end, rx_bad_crc};
         end else begin
            ev_q <= ev_q | {drop_ev, rx_type_error, rx_early_end, rx_bad_crc};
         end
      end
   end

   assign irq = |(status & mask_q);

   // =======================================================================
   // Read data.
   always @(posedge ref_clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (rd) begin
         if (a_st) begin
            prdata <= {25'h0, status};
         end else if (a_mk) begin
            prdata <= {25'h0, mask_q};
         end else if (a_ct) begin
            prdata <= {29'h0, ctrl_q};
         end else if (a_ev) begin
            prdata <= {28'h0, ev_q};
         end else if (a_lv) begin
            prdata <= {27'h0, level};
         end else if (a_dt) begin
            prdata <= {24'h000000, rd_byte};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end
endmodule

// >>> rtl/rxf_map.vh
/*
 Register offsets, field positions, reset values and counts for the receive
 status flag block. Assumes a 32-bit APB slave with word-aligned registers.
*/
`ifndef RXF_MAP_VH
`define RXF_MAP_VH
// ==========================================================================
// Register byte offsets.
`define RXF_STATUS_OFS   12'h000
`define RXF_MASK_OFS     12'h004
`define RXF_CTRL_OFS     12'h008
`define RXF_EVENT_OFS    12'h00c
`define RXF_LEVEL_OFS    12'h010
`define RXF_DATA_OFS     12'h014
// ==========================================================================
// Status bit positions.
`define RXF_ST_FULL      0
`define RXF_ST_HALF      1
`define RXF_ST_NEMPTY    2
`define RXF_ST_BUFERR    3
`define RXF_ST_DONE      4
`define RXF_ST_FAULT     5
`define RXF_ST_ZSEED     6
`define RXF_ST_W         7
// ==========================================================================
// Control bit positions and reset values.
`define RXF_CT_TRANS     0
`define RXF_CT_ACKEN     1
`define RXF_CT_GO        2
`define RXF_CTRL_RST     3'h0
`define RXF_MASK_RST     7'h00
// ==========================================================================
// Event sticky bits.
`define RXF_EV_BADCRC    0
`define RXF_EV_EARLY     1
`define RXF_EV_TYPE      2
`define RXF_EV_DROP      3
`define RXF_EV_W         4
// ==========================================================================
// Buffer geometry.
`define RXF_DEPTH        16
`define RXF_HALF_LEVEL   8
`endif
